// file: signal_monitor_dc_correction.sv
// Top of the dual-channel signal monitor with dc correction and byte register port
// What this block does
// R01 - Peak runs on mode 1 or peak enable
// R02 - Software writes period before enabling any mode
// R03 - Enabling loads period into down-counter
// R04 - Peak starts at sample, keeps larger
// R05 - At count 1 peak moves to result
// R06 - Rms runs on mode 0 or rms enable
// R07 - Square, cut to 11 bits, accumulate 24
// R08 - At count 1 root moves to result
// R09 - Power results are 20-bit per channel
// R10 - Threshold runs on mode 1x or enable
// R11 - Count samples above upper threshold
// R12 - At count 1 count moves, restarts at sample
// R13 - Shared upper threshold, no separate copy
// R14 - Monitor runs only while enable bit set
// R15 - Complex mode: A reports I/Q combined power
// R16 - Dc high-pass corner set by k field
// R17 - k above 13 acts as 13
// R18 - 14-bit dc value readable per channel
// R19 - Freeze bit holds dc estimate
// R20 - Bit 0 monitor correction, bit 1 output
// R21 - 24-bit period, at least 128 samples
// R22 - Both channels share one mode selection
// R23 - Mode from 0x112, enables from 0x111
// R24 - Mean-square reports power without root
// R25 - Magnitude is abs of corrected sample
`include "signal_monitor_map.svh"

module signal_monitor_dc_correction (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Converter samples, two's complement, on sys_clk
    input  wire logic [13:0] sampleA,
    input  wire logic [13:0] sampleB,
    // Main output data path
    output logic      [13:0] dataOutA,
    output logic      [13:0] dataOutB,
    // Byte register port
    input  wire logic [8:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata
);

    // ==========================================================
    // Register file
    logic [7:0]  dcCtrlReg, dcCtrlNext;
    logic [7:0]  sportCtrlReg, sportCtrlNext;
    logic [7:0]  monCtrlReg, monCtrlNext;
    logic [23:0] periodReg, periodNext;
    logic [12:0] upperThrReg, upperThrNext;
    logic [7:0]  rdataReg, rdataNext;
    logic [7:0]  readMux;

    // Channel wiring
    logic [13:0] dcValueA, dcValueB;
    logic [10:0] powerA, powerB;
    logic [19:0] resultA, resultB;
    logic [13:0] chanOutA, chanOutB;
    logic [13:0] outAReg, outBReg;

    // Decoded controls
    logic        monEnable;
    logic [1:0]  modeSel;
    logic        runPeak, runPower, runThreshold;
    logic        periodStart, periodEnd;
    logic [23:0] periodLoad;

    // Period timer
    signal_monitor_pkg::monState_e stateReg, stateNext;
    logic [23:0] countReg, countNext;

    // Writes to the configuration registers
    always_comb begin
        dcCtrlNext    = dcCtrlReg;
        sportCtrlNext = sportCtrlReg;
        monCtrlNext   = monCtrlReg;
        periodNext    = periodReg;
        upperThrNext  = upperThrReg;
        if (regWrite) begin
            unique case (regAddr)
                `ADDR_DC_CTRL:    dcCtrlNext = regWdata; // R16 R19 R20
                `ADDR_SERIAL_RESULT_PORT_CTRL: sportCtrlNext = regWdata; // R23
                `ADDR_MON_CTRL:   monCtrlNext = regWdata; // R23
                `ADDR_PERIOD_0:   periodNext[7:0] = regWdata; // R21
                `ADDR_PERIOD_1:   periodNext[15:8] = regWdata; // R21
                `ADDR_PERIOD_2:   periodNext[23:16] = regWdata; // R21
                `ADDR_UT_LOW:     upperThrNext[7:0] = regWdata; // R13
                `ADDR_UT_HIGH:    upperThrNext[12:8] = regWdata[4:0]; // R13
                default:          ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero, answer one cycle after regRead
    always_comb begin
        unique case (regAddr)
            `ADDR_UT_LOW:     readMux = upperThrReg[7:0];
            `ADDR_UT_HIGH:    readMux = {3'h0, upperThrReg[12:8]};
            `ADDR_DC_CTRL:    readMux = dcCtrlReg;
            `ADDR_DC_A_LOW:   readMux = dcValueA[7:0]; // R18
            `ADDR_DC_A_HIGH:  readMux = {2'h0, dcValueA[13:8]}; // R18
            `ADDR_DC_B_LOW:   readMux = dcValueB[7:0]; // R18
            `ADDR_DC_B_HIGH:  readMux = {2'h0, dcValueB[13:8]}; // R18
            `ADDR_SERIAL_RESULT_PORT_CTRL: readMux = sportCtrlReg;
            `ADDR_MON_CTRL:   readMux = monCtrlReg;
            `ADDR_PERIOD_0:   readMux = periodReg[7:0];
            `ADDR_PERIOD_1:   readMux = periodReg[15:8];
            `ADDR_PERIOD_2:   readMux = periodReg[23:16];
            `ADDR_RES_A_0:    readMux = resultA[7:0]; // R09
            `ADDR_RES_A_1:    readMux = resultA[15:8];
            `ADDR_RES_A_2:    readMux = {4'h0, resultA[19:16]};
            `ADDR_RES_B_0:    readMux = resultB[7:0]; // R09
            `ADDR_RES_B_1:    readMux = resultB[15:8];
            `ADDR_RES_B_2:    readMux = {4'h0, resultB[19:16]};
            default:          readMux = 8'h00;
        endcase
        rdataNext = regRead ? readMux : rdataReg;
    end

    // Mode decode; one selection feeds both channels so they cannot disagree
    always_comb begin
        monEnable    = monCtrlReg[`MON_EN_BIT]; // R14
        modeSel      = monCtrlReg[`MON_MODE_MSB:`MON_MODE_LSB]; // R22 R23
        runPeak      = (modeSel == `MODE_PEAK) || sportCtrlReg[`SP_PEAK_BIT]; // R01
        runPower     = (modeSel == `MODE_POWER) || sportCtrlReg[`SP_RMS_BIT]; // R06
        runThreshold = modeSel[1] || sportCtrlReg[`SP_THR_BIT]; // R10
        // Periods shorter than the minimum are stretched, not refused
        periodLoad   = (periodReg < `PERIOD_MIN) ? `PERIOD_MIN : periodReg; // R21
    end

    // Period timer: load on enable, reload when it reaches one
    always_comb begin
        stateNext   = stateReg;
        countNext   = countReg;
        periodStart = 1'b0;
        periodEnd   = 1'b0;
        unique case (stateReg)
            signal_monitor_pkg::MON_IDLE: begin
                if (monEnable) begin
                    periodStart = 1'b1;
                    countNext   = periodLoad; // R03
                    stateNext   = signal_monitor_pkg::MON_RUN;
                end
            end
            signal_monitor_pkg::MON_RUN: begin
                if (!monEnable) begin
                    stateNext = signal_monitor_pkg::MON_IDLE; // R14
                end else if (countReg == `PERIOD_LAST) begin
                    periodEnd = 1'b1; // R05 R08 R12
                    countNext = periodLoad; // R05 R08 R12
                end else begin
                    countNext = countReg - 24'h000001; // R03
                end
            end
        endcase
    end

    // Register file, timer and output stage
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dcCtrlReg    <= `BYTE_RESET;
            sportCtrlReg <= `BYTE_RESET;
            monCtrlReg   <= `BYTE_RESET;
            periodReg    <= `PERIOD_RESET;
            upperThrReg  <= `UT_RESET;
            rdataReg     <= `BYTE_RESET;
            stateReg     <= signal_monitor_pkg::MON_IDLE;
            countReg     <= 24'h000000;
            outAReg      <= 14'h0000;
            outBReg      <= 14'h0000;
        end else begin
            dcCtrlReg    <= dcCtrlNext;
            sportCtrlReg <= sportCtrlNext;
            monCtrlReg   <= monCtrlNext;
            periodReg    <= periodNext;
            upperThrReg  <= upperThrNext;
            rdataReg     <= rdataNext;
            stateReg     <= stateNext;
            countReg     <= countNext;
            outAReg      <= chanOutA;
            outBReg      <= chanOutB;
        end
    end

    // Channel A carries the combined I/Q power in complex mode
    signal_monitor_channel chanA (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .sample         (sampleA),
        .dataOut        (chanOutA),
        .dcEnable       (dcCtrlReg[`DC_EN_BIT]),
        .dcToOutput     (dcCtrlReg[`DC_OUT_BIT]),
        .dcFreeze       (dcCtrlReg[`DC_FREEZE_BIT]),
        .dcShiftK       (dcCtrlReg[`DC_K_MSB:`DC_K_LSB]),
        .dcValue        (dcValueA),
        .monEnable      (monEnable),
        .runPeak        (runPeak),
        .runPower       (runPower),
        .runThreshold   (runThreshold),
        .msSelect       (monCtrlReg[`MON_MS_BIT]),
        .modeSel        (modeSel),
        .cplxEn         (monCtrlReg[`MON_CPLX_BIT]), // R15
        .upperThreshold (upperThrReg),
        .periodStart    (periodStart),
        .periodEnd      (periodEnd),
        .partnerPower   (powerB),
        .ownPower       (powerA),
        .result         (resultA)
    );

    // Channel B always reports its own value
    signal_monitor_channel chanB (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .sample         (sampleB),
        .dataOut        (chanOutB),
        .dcEnable       (dcCtrlReg[`DC_EN_BIT]),
        .dcToOutput     (dcCtrlReg[`DC_OUT_BIT]),
        .dcFreeze       (dcCtrlReg[`DC_FREEZE_BIT]),
        .dcShiftK       (dcCtrlReg[`DC_K_MSB:`DC_K_LSB]),
        .dcValue        (dcValueB),
        .monEnable      (monEnable),
        .runPeak        (runPeak),
        .runPower       (runPower),
        .runThreshold   (runThreshold),
        .msSelect       (monCtrlReg[`MON_MS_BIT]),
        .modeSel        (modeSel),
        .cplxEn         (1'b0), // R15
        .upperThreshold (upperThrReg),
        .periodStart    (periodStart),
        .periodEnd      (periodEnd),
        .partnerPower   (powerA),
        .ownPower       (powerB),
        .result         (resultB)
    );

    assign dataOutA = outAReg;
    assign dataOutB = outBReg;
    assign regRdata = rdataReg;

endmodule

// file: signal_monitor_map.svh
// Register addresses, field positions, reset values and limits of the signal monitor
`ifndef SIGNAL_MONITOR_MAP_SVH
`define SIGNAL_MONITOR_MAP_SVH

// ==========================================================
// Register addresses
`define ADDR_UT_LOW       9'h106
`define ADDR_UT_HIGH      9'h107
`define ADDR_DC_CTRL      9'h10c
`define ADDR_DC_A_LOW     9'h10d
`define ADDR_DC_A_HIGH    9'h10e
`define ADDR_DC_B_LOW     9'h10f
`define ADDR_DC_B_HIGH    9'h110
`define ADDR_SERIAL_RESULT_PORT_CTRL   9'h111
`define ADDR_MON_CTRL     9'h112
`define ADDR_PERIOD_0     9'h113
`define ADDR_PERIOD_1     9'h114
`define ADDR_PERIOD_2     9'h115
`define ADDR_RES_A_0      9'h116
`define ADDR_RES_A_1      9'h117
`define ADDR_RES_A_2      9'h118
`define ADDR_RES_B_0      9'h119
`define ADDR_RES_B_1      9'h11a
`define ADDR_RES_B_2      9'h11b

// ==========================================================
// Field positions
`define DC_EN_BIT         0
`define DC_OUT_BIT        1
`define DC_K_LSB          2
`define DC_K_MSB          5
`define DC_FREEZE_BIT     6
`define MON_EN_BIT        0
`define MON_MODE_LSB      1
`define MON_MODE_MSB      2
`define MON_CPLX_BIT      3
`define MON_MS_BIT        4
`define SP_RMS_BIT        0
`define SP_PEAK_BIT       1
`define SP_THR_BIT        2

// ==========================================================
// Mode codes, reset values and limits
`define MODE_POWER        2'h0
`define MODE_PEAK         2'h1
`define BYTE_RESET        8'h00
`define UT_RESET          13'h0000
`define PERIOD_RESET      24'h000080
`define PERIOD_MIN        24'h000080
`define PERIOD_LAST       24'h000001
`define DC_K_MAX          4'hd
`define DC_SHIFT_BASE     6'h0e
`define MAG_MAX           13'h1fff
`define ACC_MAX           24'hffffff
`define COUNT_MAX         20'hfffff

`endif

// file: signal_monitor_pkg.sv
// Types shared by the signal monitor design files
package signal_monitor_pkg;

    // ==========================================================
    // Period timer states
    typedef enum logic [1:0] {
        MON_IDLE = 2'b01,
        MON_RUN  = 2'b10
    } monState_e;

endpackage

// file: signal_monitor_channel.sv
// One channel: dc correction, magnitude, peak, power and threshold measurement
`include "signal_monitor_map.svh"

module signal_monitor_channel (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Sample in, corrected sample out
    input  wire logic [13:0] sample,
    output logic      [13:0] dataOut,
    // Dc correction control and readback
    input  wire logic        dcEnable,
    input  wire logic        dcToOutput,
    input  wire logic        dcFreeze,
    input  wire logic [3:0]  dcShiftK,
    output logic      [13:0] dcValue,
    // Measurement control
    input  wire logic        monEnable,
    input  wire logic        runPeak,
    input  wire logic        runPower,
    input  wire logic        runThreshold,
    input  wire logic        msSelect,
    input  wire logic [1:0]  modeSel,
    input  wire logic        cplxEn,
    input  wire logic [12:0] upperThreshold,
    input  wire logic        periodStart,
    input  wire logic        periodEnd,
    // Power exchange for complex mode
    input  wire logic [10:0] partnerPower,
    output logic      [10:0] ownPower,
    // Held result
    output logic      [19:0] result
);

    // ==========================================================
    // Integer square root, bit by bit, 24 in 12 out
    function automatic logic [11:0] isqrt(input logic [23:0] v);
        logic [11:0] r;
        logic [11:0] t;
        r = 12'h000;
        for (int i = 11; i >= 0; i--) begin
            t = r | (12'h001 << i);
            if (24'(t) * 24'(t) <= v) begin
                r = t;
            end
        end
        return r;
    endfunction

    // ==========================================================
    // State
    logic signed [40:0] dcAccReg, dcAccNext;
    logic        [12:0] peakReg, peakNext;
    logic        [23:0] powAccReg, powAccNext;
    logic        [19:0] countReg, countNext;
    logic        [19:0] resultReg, resultNext;
    logic        [13:0] dataOutReg, dataOutNext;

    logic        [3:0]  kEff;
    logic        [5:0]  shiftAmt;
    logic signed [13:0] dcEst;
    logic signed [14:0] corrWide;
    logic signed [13:0] corrSat;
    logic signed [13:0] monSample;
    logic        [13:0] absVal;
    logic        [12:0] result_magnitude;
    logic        [25:0] square;
    logic        [11:0] sumPower;
    logic        [24:0] accSum;
    logic               above;

    // Dc estimate: leaky integrator, corner set by 2^-(k+14)
    always_comb begin
        kEff      = (dcShiftK > `DC_K_MAX) ? `DC_K_MAX : dcShiftK; // R17
        shiftAmt  = {2'h0, kEff} + `DC_SHIFT_BASE; // R16
        dcEst     = 14'(dcAccReg >>> shiftAmt); // R16
        corrWide  = 15'(signed'(sample)) - 15'(dcEst);
        // Saturate rather than wrap: a wrapped sample would fake a full-scale peak
        if (corrWide > 15'sh1fff) begin
            corrSat = 14'sh1fff;
        end else if (corrWide < -15'sh2000) begin
            corrSat = -14'sh2000;
        end else begin
            corrSat = corrWide[13:0];
        end
        dcAccNext = dcFreeze ? dcAccReg : dcAccReg + 41'(corrWide); // R19
        dataOutNext = dcToOutput ? corrSat : sample; // R20
    end

    // Magnitude and power of the sample the monitor sees
    always_comb begin
        monSample = dcEnable ? corrSat : signed'(sample); // R20
        absVal    = monSample[13] ? 14'(-monSample) : monSample; // R25
        result_magnitude       = absVal[13] ? `MAG_MAX : absVal[12:0];
        // Squaring the magnitude and keeping the top eleven bits stands in for the float step
        square    = 26'(result_magnitude) * 26'(result_magnitude); // R07
        ownPower  = square[25:15]; // R07
        sumPower  = (cplxEn && modeSel == `MODE_POWER)
                    ? 12'(ownPower) + 12'(partnerPower) // R15
                    : 12'(ownPower);
        above     = result_magnitude > upperThreshold; // R11 R13
        accSum    = 25'(powAccReg) + 25'(sumPower);
    end

    // Measurement registers: restart from the current sample at a period edge
    always_comb begin
        peakNext   = peakReg;
        powAccNext = powAccReg;
        countNext  = countReg;
        resultNext = resultReg;
        if (!monEnable) begin
            peakNext   = 13'h0000; // R14
            powAccNext = 24'h000000;
            countNext  = 20'h00000;
        end else if (periodStart || periodEnd) begin
            peakNext   = runPeak ? result_magnitude : 13'h0000; // R04 R05
            powAccNext = runPower ? 24'(sumPower) : 24'h000000; // R08
            countNext  = (runThreshold && above) ? 20'h00001 : 20'h00000; // R11 R12
        end else begin
            if (runPeak && result_magnitude > peakReg) begin
                peakNext = result_magnitude; // R04
            end
            if (runPower) begin
                powAccNext = accSum[24] ? `ACC_MAX : accSum[23:0]; // R07
            end
            if (runThreshold && above && countReg != `COUNT_MAX) begin
                countNext = countReg + 20'h00001; // R11
            end
        end
        if (monEnable && periodEnd) begin
            unique case (modeSel)
                `MODE_POWER: resultNext = msSelect ? powAccReg[23:4] // R24
                                                   : {isqrt(powAccReg), 8'h00}; // R08 R09
                `MODE_PEAK:  resultNext = {7'h00, peakReg}; // R05
                default:     resultNext = countReg; // R12
            endcase
        end
    end

    // Register all state of the channel
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dcAccReg   <= 41'sh0;
            peakReg    <= 13'h0000;
            powAccReg  <= 24'h000000;
            countReg   <= 20'h00000;
            resultReg  <= 20'h00000;
            dataOutReg <= 14'h0000;
        end else begin
            dcAccReg   <= dcAccNext;
            peakReg    <= peakNext;
            powAccReg  <= powAccNext;
            countReg   <= countNext;
            resultReg  <= resultNext;
            dataOutReg <= dataOutNext;
        end
    end

    assign dcValue = dcEst; // R18
    assign dataOut = dataOutReg;
    assign result  = resultReg;

endmodule

// file: signal_monitor_dc_correction_assertions.sv
// Port-level assertions for the signal monitor top, with its bind
module signal_monitor_dc_correction_assertions (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // Samples and main path
    input wire logic [13:0] sampleA,
    input wire logic [13:0] sampleB,
    input wire logic [13:0] dataOutA,
    input wire logic [13:0] dataOutB,
    // Register port
    input wire logic [8:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata
);
    // ==========================================================
    // Helper state
    logic       dcOut_reg;
    logic [1:0] upCount_reg;
    logic       raw;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Shadow of the output-correction bit; raw path judged only once the pipe has settled
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dcOut_reg   <= 1'b0;
            upCount_reg <= 2'h0;
        end else begin
            if (regWrite && regAddr == 9'h10c) dcOut_reg <= regWdata[1];
            if (upCount_reg != 2'h3) upCount_reg <= upCount_reg + 2'h1;
        end
    end
    assign raw = (upCount_reg == 2'h3) && !dcOut_reg;

    // ==========================================================
    // Properties
    rawPath_a: assert property (
        raw && $past(raw) && $past(raw, 2) |->
        dataOutA == $past(sampleA, 2) && dataOutB == $past(sampleB, 2))
        else $error("main path differs from delayed sample");
    resetVals_a: assert property (
        $fell(srst) |-> regRdata == 8'h00 && dataOutA == 14'h0000 && dataOutB == 14'h0000)
        else $error("outputs not cleared by reset");
    unmapped_a: assert property (
        regRead && !(regAddr inside {[9'h106:9'h107], [9'h10c:9'h11b]}) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    rdataHold_a: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    dcCtrlRw_a: assert property (
        regWrite && regAddr == 9'h10c ##1 regRead && !regWrite && regAddr == 9'h10c
        |=> (regRdata & 8'h7f) == ($past(regWdata, 2) & 8'h7f))
        else $error("dc control readback wrong");
    monCtrlRw_a: assert property (
        regWrite && regAddr == 9'h112 ##1 regRead && !regWrite && regAddr == 9'h112
        |=> (regRdata & 8'h1f) == ($past(regWdata, 2) & 8'h1f))
        else $error("monitor control readback wrong");
    periodRw_a: assert property (
        regWrite && regAddr inside {[9'h113:9'h115]} ##1
        regRead && !regWrite && regAddr == $past(regAddr) |=> regRdata == $past(regWdata, 2))
        else $error("period byte readback wrong");
    thrHigh_a: assert property (
        regWrite && regAddr == 9'h107 ##1 regRead && !regWrite && regAddr == 9'h107
        |=> regRdata == ($past(regWdata, 2) & 8'h1f))
        else $error("threshold high byte readback wrong");
endmodule

bind signal_monitor_dc_correction signal_monitor_dc_correction_assertions checker_i (
    .sys_clk(sys_clk), .srst(srst), .sampleA(sampleA), .sampleB(sampleB),
    .dataOutA(dataOutA), .dataOutB(dataOutB), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));

// file: sample_source.sv
// Converter sample model: two channels, held level, optional sign flip each sample
module sample_source (
    // Clock
    input  wire logic        sys_clk,
    // Levels set by the bench
    input  wire logic [13:0] levelA,
    input  wire logic [13:0] levelB,
    input  wire logic        flip,
    // Samples toward the monitor
    output logic      [13:0] sampleA = 14'h0000,
    output logic      [13:0] sampleB = 14'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    logic neg = 1'b0;
    // New sample every clock, off the sampling edge; flipping tests magnitude of negatives
    always @(negedge sys_clk) begin
        neg <= flip & ~neg;
        sampleA <= (flip & neg) ? -levelA : levelA;
        sampleB <= (flip & neg) ? -levelB : levelB;
    end
endmodule

// file: signal_monitor_dc_correction_tb_top.sv
// Self-checking bench for the signal monitor with dc correction
module signal_monitor_dc_correction_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals
    logic        sys_clk  = 1'b0;
    logic        srst     = 1'b1;
    logic [8:0]  regAddr  = 9'h000;
    logic        regWrite = 1'b0;
    logic        regRead  = 1'b0;
    logic [7:0]  regWdata = 8'h00;
    logic [13:0] levelA   = 14'h012c;
    logic [13:0] levelB   = 14'h00c8;
    logic        flip     = 1'b1;
    logic [13:0] sampleA, sampleB, dataOutA, dataOutB, dcVal, dcNew;
    logic [7:0]  regRdata;
    int          failures = 0;
    int          testsRun = 0;
    // Per mode: control byte and results for |A| = 300, |B| = 200, threshold 200
    logic [7:0]  modeCtl [6] = '{8'h03, 8'h05, 8'h07, 8'h01, 8'h11, 8'h09};
    logic [19:0] expA [6] = '{20'h0012c, 20'h00080, 20'h00080, 20'h01000, 20'h00010, 20'h01300};
    logic [19:0] expB [6] = '{20'h000c8, 20'h00000, 20'h00000, 20'h00b00, 20'h00008, 20'h00b00};

    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // Instances
    sample_source sample_source_i (
        .sys_clk(sys_clk), .levelA(levelA), .levelB(levelB), .flip(flip),
        .sampleA(sampleA), .sampleB(sampleB));
    signal_monitor_dc_correction signal_monitor_dc_correction_i (
        .sys_clk(sys_clk), .srst(srst), .sampleA(sampleA), .sampleB(sampleB),
        .dataOutA(dataOutA), .dataOutB(dataOutB), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata));

    // ==========================================================
    // Tasks; all but the timeout's close_out call entered at a falling edge so calls chain back to back
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Both strobes are lowered here; wr and rd each lower the other strobe, so none is assigned twice in one time step
    task automatic idle(input int n);
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (n) @(negedge sys_clk);
    endtask
    // A strobe left high repeats the same access harmlessly until the next call
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regRead = 1'b0;
        regWrite = 1'b1;
        @(negedge sys_clk);
    endtask
    // Read data is settled one edge after the strobe is taken
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        regAddr = a;
        regWrite = 1'b0;
        regRead = 1'b1;
        @(negedge sys_clk);
        d = regRdata;
    endtask
    task automatic rdc(input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check({16'h0000, d}, {16'h0000, e});
    endtask
    task automatic rdRes(input logic [8:0] a, input logic [19:0] e);
        logic [7:0] b0, b1, b2;
        rd(a, b0);
        rd(a + 9'h001, b1);
        rd(a + 9'h002, b2);
        check({b2, b1, b0}, {4'h0, e});
    endtask
    task automatic rdDc(output logic [13:0] v);
        logic [7:0] lo, hi;
        rd(9'h10d, lo);
        rd(9'h10e, hi);
        v = {hi[5:0], lo};
    endtask
    task automatic close_out();
        if (failures == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        srst = 1'b0;
        // Reset values, map and field widths
        rdc(9'h10c, 8'h00);
        rdc(9'h112, 8'h00);
        rdc(9'h113, 8'h80);
        rdc(9'h115, 8'h00);
        rdc(9'h100, 8'h00);
        wr(9'h114, 8'h12);
        rdc(9'h114, 8'h12);
        wr(9'h114, 8'h00);
        wr(9'h113, 8'h80);
        wr(9'h10c, 8'h3c);
        rdc(9'h10c, 8'h3c);
        wr(9'h107, 8'hff);
        rdc(9'h107, 8'h1f);
        wr(9'h107, 8'h00);
        wr(9'h106, 8'hc8);
        // Every mode from a fresh start; three periods pass before reading
        for (int i = 0; i < 6; i++) begin
            wr(9'h112, 8'h00);
            wr(9'h112, modeCtl[i]);
            rdc(9'h112, modeCtl[i]);
            idle(400);
            rdRes(9'h116, expA[i]);
            rdRes(9'h119, expB[i]);
        end
        // Disabled monitor keeps its last result while the input changes
        wr(9'h112, 8'h00);
        flip = 1'b0;
        levelA = 14'h0064;
        idle(300);
        rdRes(9'h116, expA[5]);
        // Dc estimate on a constant input, then freeze and correct the main path
        wr(9'h10c, 8'h01);
        idle(20000);
        wr(9'h10c, 8'h41);
        rdDc(dcVal);
        check({23'h0, dcVal != 14'h0000}, 24'h000001);
        check({10'h000, dataOutA}, {10'h000, levelA});
        wr(9'h10c, 8'h43);
        idle(1000);
        rdDc(dcNew);
        check({10'h000, dcNew}, {10'h000, dcVal});
        check({10'h000, dataOutA}, {10'h000, levelA - dcVal});
        wr(9'h10c, 8'h03);
        idle(2000);
        rdDc(dcNew);
        check({23'h0, dcNew > dcVal}, 24'h000001);
        close_out();
    end

    // Cut a hang short
    initial begin
        repeat (40000) @(posedge sys_clk);
        failures++;
        close_out();
    end
endmodule
